// ### shared/swout_pkg.sv
/*
 Constants, register map and carriers for the switch output controller.
 Assumes a 20 MHz clock and a classic Wishbone slave with 32-bit data.
*/
// Contract
// - on above off: close when value exceeds on
// - on above off: open when value below off
// - on below off: close when value below on
// - on below off: open when value exceeds off
// - limit mode waits switch-on delay before closing
// - limit mode waits switch-off delay before opening
// - error forces failure state: hold, open, closed; the code applies it in limit and digital-output modes only
// - present switch state readable as status
// - inversion swaps open and closed states
// - off mode always open, on always closed
// - diagnostic mode opens only on selected event class
// - digital-output mode tracks selected source block
`default_nettype none
package swout_pkg;
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned TICK_MS       = 100;
	localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
	localparam logic [9:0]  DELAY_MAX     = 10'h3E8;

	localparam logic [3:0] ADR_CTRL   = 4'h0;
	localparam logic [3:0] ADR_ON_VAL = 4'h4;
	localparam logic [3:0] ADR_OFF_VAL= 4'h8;
	localparam logic [3:0] ADR_DELAY  = 4'hC;
	localparam logic [3:0] ADR_STATUS = 4'h0;
	localparam logic [7:0] ADR_STAT_W = 8'h10;

	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] DELAY_RST = 32'h0000_0000;

	typedef enum logic [2:0] {
		FN_OFF = 3'h0, FN_ON = 3'h1, FN_DIAG = 3'h2, FN_LIMIT = 3'h3, FN_DOUT = 3'h4
	} func_e;
	typedef enum logic [1:0] {FAIL_HOLD = 2'h0, FAIL_OPEN = 2'h1, FAIL_CLOSED = 2'h2} fail_e;
	typedef enum logic [1:0] {DC_ALARM = 2'h0, DC_ALARM_WARN = 2'h1, DC_WARN = 2'h2} diag_e;
	typedef enum logic [1:0] {LS_OPEN = 2'b00, LS_WAIT_ON = 2'b01,
		LS_CLOSED = 2'b11, LS_WAIT_OFF = 2'b10} lim_e;

	// ctrl word layout, high bits first
	typedef struct packed {
		logic [19:0] rsv;
		logic        invert;
		logic        limit_off;
		logic [1:0]  dout_sel;
		diag_e       diag_cls;
		fail_e       fail;
		logic        rsv2;
		func_e       func;
	} ctrl_s;

	typedef struct packed {
		logic [5:0] rsv;
		logic [9:0] off_dly;
		logic [5:0] rsv2;
		logic [9:0] on_dly;
	} delay_s;

	typedef struct packed {
		logic alarm;
		logic warning;
	} diag_s;
endpackage
`default_nettype wire

// ### hdl/swout_ctrl.sv
/*
 Switch output controller: limit comparison with hysteresis and delays,
 failure override, inversion, and a classic Wishbone register slave.
 Assumes the process value and discrete inputs are synchronous to clock_i.
*/
`timescale 1ns/1ns
`default_nettype none
module swout_ctrl #(
	parameter int unsigned TICK_CYCLES = swout_pkg::TICK_CYCLES
) (
	input  wire logic              clock_i,
	input  wire logic              sys_rst_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic signed [31:0] pv_i,
	input  wire logic              pv_err_i,
	input  wire swout_pkg::diag_s  diag_i,
	input  wire logic [1:0]        dout_src_i,
	output logic                   switch_closed_o
);
	swout_pkg::ctrl_s  ctrl_r, ctrl_nxt;
	swout_pkg::delay_s dly_r, dly_nxt;
	logic signed [31:0] on_val_r, on_val_nxt, off_val_r, off_val_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic        ack_r, ack_nxt;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [9:0] clamp(input logic [9:0] v);
		return (v > swout_pkg::DELAY_MAX) ? swout_pkg::DELAY_MAX : v;
	endfunction

	// tick divider: one pulse each 0.1 s
	// phase runs free, so a delay may end up to one tick early
	logic [$clog2(TICK_CYCLES)-1:0] div_r, div_nxt;
	logic tick_r, tick_nxt;
	always_comb begin
		tick_nxt = 1'b0;
		div_nxt  = div_r + 1'b1;
		if (div_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
			div_nxt  = '0;
			tick_nxt = 1'b1;
		end
	end
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			div_r  <= div_nxt;
			tick_r <= tick_nxt;
		end
	end

	// limit comparator with hysteresis and delays
	swout_pkg::lim_e st_r, st_nxt;
	logic [9:0] cnt_r, cnt_nxt;
	logic want_close, want_open, limit_en;
	always_comb begin
		limit_en = (ctrl_r.func == swout_pkg::FN_LIMIT) && !ctrl_r.limit_off;
		// equal thresholds take the second branch: close below, open above
		if (on_val_r > off_val_r) begin
			want_close = pv_i > on_val_r;
			want_open  = pv_i < off_val_r;
		end else begin
			want_close = pv_i < on_val_r;
			want_open  = pv_i > off_val_r;
		end
		st_nxt  = st_r;
		cnt_nxt = cnt_r;
		if (!limit_en) begin
			st_nxt  = swout_pkg::LS_OPEN;
			cnt_nxt = '0;
		end else begin
			case (st_r)
				swout_pkg::LS_OPEN: begin
					cnt_nxt = '0;
					if (want_close) begin
						st_nxt = swout_pkg::LS_WAIT_ON;
					end
				end
				swout_pkg::LS_WAIT_ON: begin
					if (!want_close) begin
						st_nxt  = swout_pkg::LS_OPEN;
						cnt_nxt = '0;
					end else if (cnt_r >= clamp(dly_r.on_dly)) begin
						st_nxt  = swout_pkg::LS_CLOSED;
						cnt_nxt = '0;
					end else if (tick_r) begin
						cnt_nxt = cnt_r + 1'b1;
					end
				end
				swout_pkg::LS_CLOSED: begin
					cnt_nxt = '0;
					if (want_open) begin
						st_nxt = swout_pkg::LS_WAIT_OFF;
					end
				end
				swout_pkg::LS_WAIT_OFF: begin
					if (!want_open) begin
						st_nxt  = swout_pkg::LS_CLOSED;
						cnt_nxt = '0;
					end else if (cnt_r >= clamp(dly_r.off_dly)) begin
						st_nxt  = swout_pkg::LS_OPEN;
						cnt_nxt = '0;
					end else if (tick_r) begin
						cnt_nxt = cnt_r + 1'b1;
					end
				end
				default: begin
					st_nxt  = swout_pkg::LS_OPEN;
					cnt_nxt = '0;
				end
			endcase
		end
	end
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_r  <= swout_pkg::LS_OPEN;
			cnt_r <= '0;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// output selection, failure override and inversion
	logic base, diag_hit, failed, closed_nxt, closed_r, out_nxt, out_r;
	always_comb begin
		case (ctrl_r.diag_cls)
			swout_pkg::DC_ALARM:      diag_hit = diag_i.alarm;
			swout_pkg::DC_ALARM_WARN: diag_hit = diag_i.alarm | diag_i.warning;
			swout_pkg::DC_WARN:       diag_hit = diag_i.warning;
			default:                  diag_hit = diag_i.alarm;
		endcase
		case (ctrl_r.func)
			swout_pkg::FN_OFF:   base = 1'b0;
			swout_pkg::FN_ON:    base = 1'b1;
			swout_pkg::FN_DIAG:  base = !diag_hit;
			swout_pkg::FN_LIMIT: base = (st_r == swout_pkg::LS_CLOSED) ||
				(st_r == swout_pkg::LS_WAIT_OFF);
			swout_pkg::FN_DOUT:  base = (ctrl_r.dout_sel == 2'h1) ? dout_src_i[0] :
				(ctrl_r.dout_sel == 2'h2) ? dout_src_i[1] : 1'b0;
			default:             base = 1'b0;
		endcase
		failed = pv_err_i && ((ctrl_r.func == swout_pkg::FN_LIMIT) ||
			(ctrl_r.func == swout_pkg::FN_DOUT));
		// hold keeps the pre-inversion state, so inversion still applies on top
		closed_nxt = base;
		if (failed) begin
			case (ctrl_r.fail)
				swout_pkg::FAIL_OPEN:   closed_nxt = 1'b0;
				swout_pkg::FAIL_CLOSED: closed_nxt = 1'b1;
				default:                closed_nxt = closed_r;
			endcase
		end
		out_nxt = closed_nxt ^ ctrl_r.invert;
	end
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			closed_r <= 1'b0;
			out_r    <= 1'b0;
		end else begin
			closed_r <= closed_nxt;
			out_r    <= out_nxt;
		end
	end
	assign switch_closed_o = out_r;

	// wishbone slave, ack one cycle after the request
	logic req;
	always_comb begin
		req         = wb_cyc_i && wb_stb_i && !ack_r;
		ctrl_nxt    = ctrl_r;
		dly_nxt     = dly_r;
		on_val_nxt  = on_val_r;
		off_val_nxt = off_val_r;
		dat_nxt     = dat_r;
		ack_nxt     = req;
		if (req && wb_we_i) begin
			case (wb_adr_i)
				{4'h0, swout_pkg::ADR_CTRL}:    ctrl_nxt = merge(ctrl_r, wb_dat_i, wb_sel_i);
				{4'h0, swout_pkg::ADR_ON_VAL}:  on_val_nxt = merge(on_val_r, wb_dat_i, wb_sel_i);
				{4'h0, swout_pkg::ADR_OFF_VAL}: off_val_nxt = merge(off_val_r, wb_dat_i, wb_sel_i);
				{4'h0, swout_pkg::ADR_DELAY}:   dly_nxt = merge(dly_r, wb_dat_i, wb_sel_i);
				default: ;
			endcase
			ctrl_nxt.rsv  = '0;
			ctrl_nxt.rsv2 = 1'b0;
			dly_nxt.rsv   = '0;
			dly_nxt.rsv2  = '0;
		end
		if (req && !wb_we_i) begin
			case (wb_adr_i)
				{4'h0, swout_pkg::ADR_CTRL}:    dat_nxt = ctrl_r;
				{4'h0, swout_pkg::ADR_ON_VAL}:  dat_nxt = on_val_r;
				{4'h0, swout_pkg::ADR_OFF_VAL}: dat_nxt = off_val_r;
				{4'h0, swout_pkg::ADR_DELAY}:   dat_nxt = dly_r;
				swout_pkg::ADR_STAT_W:          dat_nxt = {29'h0, st_r, out_r};
				default:                        dat_nxt = 32'h0;
			endcase
		end
	end
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_r    <= swout_pkg::CTRL_RST;
			dly_r     <= swout_pkg::DELAY_RST;
			on_val_r  <= 32'h0000_0000;
			off_val_r <= 32'h0000_0000;
			dat_r     <= 32'h0000_0000;
			ack_r     <= 1'b0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			dly_r     <= dly_nxt;
			on_val_r  <= on_val_nxt;
			off_val_r <= off_val_nxt;
			dat_r     <= dat_nxt;
			ack_r     <= ack_nxt;
		end
	end
	assign wb_dat_o = dat_r;
	assign wb_ack_o = ack_r;

	// checks
	sequence s_close_cond;
		limit_en && want_close && !pv_err_i;
	endsequence

	a_off_open: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ctrl_r.func == swout_pkg::FN_OFF && !ctrl_r.invert |=> !switch_closed_o)
		else $error("off mode output not open");
	a_on_closed: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ctrl_r.func == swout_pkg::FN_ON && !ctrl_r.invert |=> switch_closed_o)
		else $error("on mode output not closed");
	a_invert_swap: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		1'b1 |=> switch_closed_o == (closed_r ^ $past(ctrl_r.invert)))
		else $error("inversion wrong");
	a_fail_open: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		failed && ctrl_r.fail == swout_pkg::FAIL_OPEN |=> closed_r == 1'b0)
		else $error("failure open not forced");
	a_fail_closed: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		failed && ctrl_r.fail == swout_pkg::FAIL_CLOSED |=> closed_r)
		else $error("failure closed not forced");
	a_zero_delay: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		st_r == swout_pkg::LS_OPEN && dly_r.on_dly == 10'h0 && want_close && limit_en
		##1 s_close_cond |=> st_r == swout_pkg::LS_CLOSED)
		else $error("zero switch-on delay not honoured");
	a_cancel_wait: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		st_r == swout_pkg::LS_WAIT_ON && limit_en && !want_close
		|=> st_r == swout_pkg::LS_OPEN && cnt_r == 10'h0)
		else $error("pending close not cancelled");
	a_diag_open: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ctrl_r.func == swout_pkg::FN_DIAG |=> closed_r == !$past(diag_hit))
		else $error("diagnostic mode output wrong");
	a_ack_pulse: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_close_rise: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		limit_en && on_val_r > off_val_r && st_r == swout_pkg::LS_OPEN &&
		pv_i > on_val_r |=> st_r == swout_pkg::LS_WAIT_ON)
		else $error("rising close not started");
	a_open_fall: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		limit_en && on_val_r > off_val_r && st_r == swout_pkg::LS_CLOSED &&
		pv_i < off_val_r |=> st_r == swout_pkg::LS_WAIT_OFF)
		else $error("falling open not started");
	a_hold_closed: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		limit_en && st_r == swout_pkg::LS_CLOSED && !want_open
		|=> st_r == swout_pkg::LS_CLOSED)
		else $error("closed state left inside the band");
	a_hold_open: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		limit_en && st_r == swout_pkg::LS_OPEN && !want_close
		|=> st_r == swout_pkg::LS_OPEN)
		else $error("open state left inside the band");
	a_cancel_open: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		st_r == swout_pkg::LS_WAIT_OFF && limit_en && !want_open
		|=> st_r == swout_pkg::LS_CLOSED && cnt_r == 10'h0)
		else $error("pending open not cancelled");
	a_on_wait: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		limit_en && st_r == swout_pkg::LS_WAIT_ON && cnt_r < dly_r.on_dly &&
		dly_r.on_dly <= swout_pkg::DELAY_MAX |=> st_r != swout_pkg::LS_CLOSED)
		else $error("closed before switch-on delay");
	a_off_wait: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		limit_en && st_r == swout_pkg::LS_WAIT_OFF && cnt_r < dly_r.off_dly &&
		dly_r.off_dly <= swout_pkg::DELAY_MAX |=> st_r != swout_pkg::LS_OPEN)
		else $error("opened before switch-off delay");
	a_fail_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		failed && ctrl_r.fail == swout_pkg::FAIL_HOLD
		|=> closed_r == $past(closed_r))
		else $error("failure hold changed the output");
	a_dout_track: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ctrl_r.func == swout_pkg::FN_DOUT && !failed && ctrl_r.dout_sel == 2'h2
		|=> closed_r == $past(dout_src_i[1]))
		else $error("digital output not tracked");
	a_status_bit: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		req && !wb_we_i && wb_adr_i == swout_pkg::ADR_STAT_W
		|=> wb_dat_o[0] == $past(switch_closed_o))
		else $error("status bit differs from the output");
endmodule // swout_ctrl
`default_nettype wire

// ### tb/swload_model.sv
/*
 Load circuit on the switch output: current flows only while closed.
 Assumes the switch level is already synchronous to the bench clock.
*/
`timescale 1ns/1ns
`default_nettype none
module swload_model (
	input  wire logic closed_i,
	output logic      current_o
);
	// a resistive load, so current follows the contact with no memory
	assign current_o = closed_i;
endmodule // swload_model
`default_nettype wire

// ### tb/tb.sv
/*
 Self-checking bench for the switch output controller.
 Assumes swout_pkg is compiled first; the delay tick is shortened to 20 cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
	localparam int unsigned TICK = 20;
	logic               clock_i   = 1'b0;
	logic               sys_rst_i = 1'b1;
	logic               cyc  = 1'b0;
	logic               stb  = 1'b0;
	logic               we   = 1'b0;
	logic [7:0]         adr  = 8'h00;
	logic [3:0]         sel  = 4'hF;
	logic [31:0]        wdat = 32'h0;
	logic [31:0]        rdat;
	logic               ack;
	logic signed [31:0] pv   = 32'sh0;
	logic               err  = 1'b0;
	swout_pkg::diag_s   diag = '0;
	logic [1:0]         src  = 2'h0;
	logic               closed;
	logic               current;
	logic [31:0]        rd;
	integer             seed = 32'hBD57D95D;
	int                 fails = 0;
	int                 total_checks = 0;
	int                 cycles = 0;

	swout_ctrl #(.TICK_CYCLES(TICK)) uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pv_i(pv), .pv_err_i(err),
		.diag_i(diag), .dout_src_i(src), .switch_closed_o(closed));
	swload_model load (.closed_i(closed), .current_o(current));

	initial begin
		forever #25 clock_i = ~clock_i;
	end

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// hangs only end here, so bus waits need no count of their own
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do @(posedge clock_i); while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask

	// waits a bounded time for the level, then checks switch and load current
	task automatic wait_sw(input logic exp, input int n);
		for (int i = 0; i < n && closed !== exp; i++) @(posedge clock_i);
		chk({30'h0, current, closed}, {30'h0, exp, exp});
	endtask

	function automatic logic diag_closed(input int c, input logic [1:0] d);
		return !((c == 0 && d[1]) || (c == 1 && d != 2'h0) || (c == 2 && d[0]));
	endfunction

	initial begin
		repeat (4) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		wb(1'b0, 8'h00, 32'h0);
		chk(rd, swout_pkg::CTRL_RST);
		wb(1'b1, 8'h20, 32'hFFFF_FFFF);
		wb(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, 8'h00, {20'h0, i[1], 10'h0, i[0]});
			wait_sw(i[0] ^ i[1], 10);
			wb(1'b0, swout_pkg::ADR_STAT_W, 32'h0);
			chk(rd & 32'h1, {31'h0, i[0] ^ i[1]});
		end
		$display("fixed modes done");
		wb(1'b1, 8'h04, 32'h64);
		wb(1'b1, 8'h08, 32'h32);
		wb(1'b1, 8'h0C, 32'h0);
		wb(1'b1, 8'h00, 32'h3);
		for (int k = 0; k < 6; k++) begin
			pv <= 32'h65 + ($random(seed) & 32'hFF);
			wait_sw(1'b1, 10);
			pv <= 32'h40 + ($random(seed) & 32'h1F);
			repeat (10) @(posedge clock_i);
			wait_sw(1'b1, 0);
			pv <= 32'h31 - ($random(seed) & 32'hFF);
			wait_sw(1'b0, 10);
			pv <= 32'h40 + ($random(seed) & 32'h1F);
			repeat (10) @(posedge clock_i);
			wait_sw(1'b0, 0);
		end
		pv <= 32'h64;
		repeat (10) @(posedge clock_i);
		wait_sw(1'b0, 0);
		wb(1'b1, 8'h04, 32'hFFFF_FFCE);
		for (int k = 0; k < 4; k++) begin
			pv <= 32'hFFFF_FFCD - ($random(seed) & 32'hFF);
			wait_sw(1'b1, 10);
			pv <= 32'h33 + ($random(seed) & 32'hFF);
			wait_sw(1'b0, 10);
		end
		$display("limit thresholds done");
		pv <= 32'h0;
		wb(1'b1, 8'h04, 32'h64);
		wb(1'b1, 8'h0C, 32'h0003_0005);
		wait_sw(1'b0, 10);
		pv <= 32'hC8;
		repeat (60) @(posedge clock_i);
		pv <= 32'h50;
		repeat (50) @(posedge clock_i);
		wait_sw(1'b0, 0);
		pv <= 32'hC8;
		repeat (70) @(posedge clock_i);
		wait_sw(1'b0, 0);
		wait_sw(1'b1, 60);
		wb(1'b0, swout_pkg::ADR_STAT_W, 32'h0);
		chk(rd & 32'h7, 32'h7);
		pv <= 32'h0;
		repeat (30) @(posedge clock_i);
		wait_sw(1'b1, 0);
		wait_sw(1'b0, 50);
		$display("delays done");
		wb(1'b1, 8'h0C, 32'h0);
		wb(1'b1, 8'h00, 32'h13);
		pv <= 32'hC8;
		wait_sw(1'b1, 10);
		err <= 1'b1;
		wait_sw(1'b0, 10);
		wb(1'b1, 8'h00, 32'h23);
		pv <= 32'h0;
		wait_sw(1'b1, 10);
		err <= 1'b0;
		wb(1'b1, 8'h00, 32'h03);
		wait_sw(1'b0, 10);
		err <= 1'b1;
		pv <= 32'hC8;
		repeat (10) @(posedge clock_i);
		wait_sw(1'b0, 0);
		err <= 1'b0;
		$display("failure modes done");
		for (int c = 0; c < 3; c++) begin
			wb(1'b1, 8'h00, {24'h0, c[1:0], 6'h2});
			for (int j = 0; j < 4; j++) begin
				diag <= swout_pkg::diag_s'(j[1:0]);
				repeat (3) @(posedge clock_i);
				wait_sw(diag_closed(c, j[1:0]), 0);
			end
		end
		for (int s = 1; s < 3; s++) begin
			wb(1'b1, 8'h00, {22'h0, s[1:0], 8'h4});
			for (int j = 0; j < 4; j++) begin
				src <= 2'(j ^ $random(seed));
				repeat (3) @(posedge clock_i);
				wait_sw(src[s-1], 0);
			end
		end
		src <= 2'h3;
		wb(1'b1, 8'h00, 32'h0000_0004);
		repeat (3) @(posedge clock_i);
		wait_sw(1'b0, 0);
		pv <= 32'hC8;
		wb(1'b1, 8'h00, 32'h0000_0403);
		repeat (10) @(posedge clock_i);
		wait_sw(1'b0, 0);
		sel <= 4'h1;
		wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
		sel <= 4'hF;
		wb(1'b0, 8'h0C, 32'h0);
		chk(rd, 32'h0000_00FF);
		wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
		wb(1'b0, 8'h0C, 32'h0);
		chk(rd, 32'h03FF_03FF);
		$display("diagnostic and digital modes done");
		wrap_up();
	end
endmodule // tb
`default_nettype wire
